/* design/pct_cfg.svh */
`ifndef PCT_CFG_SVH
`define PCT_CFG_SVH
// register byte offsets
`define PCT_OFF_CTRL      8'h00
`define PCT_OFF_IOCTL     8'h04
`define PCT_OFF_COUNT     8'h08
`define PCT_OFF_GRA       8'h0C
`define PCT_OFF_GRB       8'h10
`define PCT_OFF_GRC       8'h14
`define PCT_OFF_GRD       8'h18
`define PCT_OFF_FLAGS     8'h1C
`define PCT_OFF_IEN       8'h20
`define PCT_OFF_MODE      8'h24
`define PCT_OFF_IRQCTL    8'h28
`define PCT_OFF_STANDBY   8'h2C
`define PCT_OFF_ISTAT     8'h30
`define PCT_OFF_IMASK     8'h34
// field positions
`define PCT_CTRL_CKS_LO   0
`define PCT_CTRL_CLR_LO   5
`define PCT_IO_MODE_BIT   2
`define PCT_IO_BUF_BIT    3
`define PCT_FLAG_A_BIT    0
`define PCT_IEN_A_BIT     0
`define PCT_MODE_START    7
`define PCT_IC_REQ_BIT    3
`define PCT_STBY_BIT      6
// encodings
`define PCT_CKS_OSC40     3'h6
`define PCT_CLR_GRA       2'h1
`define PCT_IOA_NOPIN     2'h0
`define PCT_FLAGS_REARM   8'h0F
// reset values
`define PCT_RST_STANDBY   8'h40
`define PCT_RST_GR        16'hFFFF
`define PCT_RST_ZERO8     8'h00
`define PCT_RST_ZERO16    16'h0000
`endif

/* design/pct_pkg.sv */
package pct_pkg;
  typedef enum logic [1:0] {
    PCT_FS_IDLE = 2'b00,
    PCT_FS_READ = 2'b01,
    PCT_FS_CLR = 2'b10
  } pct_clr_e;
  typedef logic [15:0] pct_word_t;
endpackage

/* design/pct_sticky.sv */
`timescale 1ns/10ps
module pct_sticky
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);
  // set beats clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end
endmodule

/* design/pct_top.sv */
// Function
// - the three-bit count source field picks the count clock, 1 1 0 meaning the 40 MHz oscillator clock.
// - with clear source 0 1 the counter returns to zero on a match with compare register A.
// - with channel A io field 0 0 a match never drives the channel A pin, which stays a port.
// - channel A mode bit 0 makes register A an output compare register.
// - buffer select bit 0 keeps register C an ordinary register, not a buffer for A.
// - the counter is 16 bits, read/write, and steps once per count source clock from zero to all ones.
// - register A holds a 16-bit compare value and a match is signalled when the counter equals it.
// - the channel A flag clears only when software reads it set and then writes 0 to it.
// - with the channel A enable bit 1 a set flag makes an interrupt request, with it 0 it does not.
// - setting the start bit b7 of the mode register makes the counter count.
// - the three-bit priority field sets the interrupt level, 0 0 1 meaning level 1.
// - priority field 0 0 0 is level 0, the interrupt disabled.
// - standby bit 0 makes the timer active so it can be accessed and can count.
`timescale 1ns/10ps
`include "pct_cfg.svh"
module pct_top
  import pct_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan_a_pin_i,
  output logic chan_a_pin_o,
  output logic chan_a_pin_oe_n_o,
  output logic [2:0] irq_level_o,
  output logic irq_o
);
  logic [7:0] ctrl_r;
  logic [7:0] ioctl_r;
  pct_word_t count_r;
  pct_word_t gra_r, grb_r, grc_r, grd_r;
  logic [7:0] ien_r;
  logic [7:0] mode_r;
  logic [2:0] prio_r;
  logic [7:0] standby_r;
  logic [7:0] imask_r;
  logic chan_a_match_flag;
  logic irq_request_pending;
  logic istat_match;
  pct_clr_e clr_st_r;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic wr_go, rd_go, wr_ok, count_en, match, flag_clr, req_set, req_clr;
  logic [7:0] wb0;

  // write channel capture, either order
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wb0 = w_data_r[7:0];
  assign wr_ok = w_strb_r[0];
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_go)
    begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_go)
    begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r > `PCT_OFF_IMASK || aw_addr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read path, one cycle latency
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      s_axi_arready <= 1'b1;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `PCT_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
        `PCT_OFF_IOCTL: s_axi_rdata <= {24'h000000, ioctl_r};
        `PCT_OFF_COUNT: s_axi_rdata <= {16'h0000, count_r};
        `PCT_OFF_GRA: s_axi_rdata <= {16'h0000, gra_r};
        `PCT_OFF_GRB: s_axi_rdata <= {16'h0000, grb_r};
        `PCT_OFF_GRC: s_axi_rdata <= {16'h0000, grc_r};
        `PCT_OFF_GRD: s_axi_rdata <= {16'h0000, grd_r};
        `PCT_OFF_FLAGS: s_axi_rdata <= {31'h00000000, chan_a_match_flag};
        `PCT_OFF_IEN: s_axi_rdata <= {24'h000000, ien_r};
        `PCT_OFF_MODE: s_axi_rdata <= {24'h000000, mode_r};
        `PCT_OFF_IRQCTL: s_axi_rdata <= {28'h0000000, irq_request_pending, prio_r};
        `PCT_OFF_STANDBY: s_axi_rdata <= {24'h000000, standby_r};
        `PCT_OFF_ISTAT: s_axi_rdata <= {31'h00000000, istat_match};
        `PCT_OFF_IMASK: s_axi_rdata <= {24'h000000, imask_r};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= `PCT_RST_ZERO8;
      ioctl_r <= `PCT_RST_ZERO8;
      ien_r <= `PCT_RST_ZERO8;
      mode_r <= `PCT_RST_ZERO8;
      prio_r <= 3'h0;
      standby_r <= `PCT_RST_STANDBY;
      imask_r <= `PCT_RST_ZERO8;
      gra_r <= `PCT_RST_GR;
      grb_r <= `PCT_RST_GR;
      grc_r <= `PCT_RST_GR;
      grd_r <= `PCT_RST_GR;
    end
    else if (wr_go && wr_ok)
    begin
      case (aw_addr_r)
        `PCT_OFF_CTRL: ctrl_r <= {1'b0, wb0[6:0]};
        `PCT_OFF_IOCTL: ioctl_r <= wb0;
        `PCT_OFF_GRA: gra_r <= w_data_r[15:0];
        `PCT_OFF_GRB: grb_r <= w_data_r[15:0];
        `PCT_OFF_GRC: grc_r <= w_data_r[15:0];
        `PCT_OFF_GRD: grd_r <= w_data_r[15:0];
        `PCT_OFF_IEN: ien_r <= {4'h0, wb0[3:0]};
        `PCT_OFF_MODE: mode_r <= wb0;
        `PCT_OFF_IRQCTL: prio_r <= wb0[2:0];
        `PCT_OFF_STANDBY: standby_r <= wb0;
        `PCT_OFF_IMASK: imask_r <= {7'h00, wb0[0]};
        default: ;
      endcase
    end
  end

  // counting enabled by start bit, active module and oscillator source
  assign count_en = mode_r[`PCT_MODE_START]
    && !standby_r[`PCT_STBY_BIT]
    && ctrl_r[`PCT_CTRL_CKS_LO +: 3] == `PCT_CKS_OSC40;
  // compare only while register A is an output compare register
  assign match = count_en && !ioctl_r[`PCT_IO_MODE_BIT] && count_r == gra_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_r <= `PCT_RST_ZERO16;
    else if (wr_go && wr_ok && aw_addr_r == `PCT_OFF_COUNT)
      count_r <= w_data_r[15:0];
    else if (match && ctrl_r[`PCT_CTRL_CLR_LO +: 2] == `PCT_CLR_GRA)
      count_r <= `PCT_RST_ZERO16;
    else if (count_en)
      count_r <= count_r + 16'h0001;
  end

  // flag clear needs a read that saw it set, then a write of 0
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      clr_st_r <= PCT_FS_IDLE;
    else
    begin
      case (clr_st_r)
        PCT_FS_IDLE:
          if (rd_go && s_axi_araddr == `PCT_OFF_FLAGS && chan_a_match_flag)
            clr_st_r <= PCT_FS_READ;
        PCT_FS_READ:
          if (wr_go && aw_addr_r == `PCT_OFF_FLAGS)
            clr_st_r <= (wr_ok && !wb0[`PCT_FLAG_A_BIT]) ? PCT_FS_CLR : PCT_FS_IDLE;
        PCT_FS_CLR:
          if (wr_go && aw_addr_r == `PCT_OFF_FLAGS)
            clr_st_r <= PCT_FS_IDLE;
        default: clr_st_r <= PCT_FS_IDLE;
      endcase
    end
  end

  assign flag_clr = clr_st_r == PCT_FS_READ && wr_go && wr_ok
    && aw_addr_r == `PCT_OFF_FLAGS && !wb0[`PCT_FLAG_A_BIT];
  assign req_set = chan_a_match_flag && ien_r[`PCT_IEN_A_BIT] && prio_r != 3'h0;
  assign req_clr = (wr_go && wr_ok && aw_addr_r == `PCT_OFF_IRQCTL && !wb0[`PCT_IC_REQ_BIT])
    || !ien_r[`PCT_IEN_A_BIT] || prio_r == 3'h0;

  pct_sticky u_flag_a
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(match),
    .clr_i(flag_clr),
    .q_o(chan_a_match_flag)
  );

  pct_sticky u_req
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(req_set),
    .clr_i(req_clr),
    .q_o(irq_request_pending)
  );

  pct_sticky u_istat
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(match),
    .clr_i(wr_go && wr_ok && aw_addr_r == `PCT_OFF_ISTAT && wb0[0]),
    .q_o(istat_match)
  );

  // pin stays a port; input synchronised for completeness
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      chan_a_pin_o <= 1'b0;
      chan_a_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      pin_s1_r <= chan_a_pin_i;
      pin_s2_r <= pin_s1_r;
      chan_a_pin_o <= 1'b0;
      chan_a_pin_oe_n_o <= 1'b1;
    end
  end

  // interrupt outputs; register C never feeds A when buffer bit is 0
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_o <= 1'b0;
      irq_level_o <= 3'h0;
    end
    else
    begin
      irq_o <= (irq_request_pending || (istat_match && imask_r[0])) && prio_r != 3'h0;
      irq_level_o <= irq_request_pending ? prio_r : 3'h0;
    end
  end

  AST_MATCH_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    match && ctrl_r[6:5] == `PCT_CLR_GRA && !(wr_go && aw_addr_r == `PCT_OFF_COUNT) |=> count_r == 16'h0000)
    else $error("counter not cleared on match");
  AST_COUNT_STEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_en && !match && !(wr_go && aw_addr_r == `PCT_OFF_COUNT) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step");
  AST_STOP_HOLDS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !mode_r[7] && !(wr_go && aw_addr_r == `PCT_OFF_COUNT) |=> $stable(count_r))
    else $error("counter moved while stopped");
  AST_STANDBY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    standby_r[6] && !(wr_go && aw_addr_r == `PCT_OFF_COUNT) |=> $stable(count_r))
    else $error("counting in standby");
  AST_SRC_SEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ctrl_r[2:0] != 3'h6 && !(wr_go && aw_addr_r == `PCT_OFF_COUNT) |=> $stable(count_r))
    else $error("counting with wrong source");
  AST_FLAG_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    match |=> chan_a_match_flag)
    else $error("flag not set on match");
  AST_FLAG_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chan_a_match_flag && clr_st_r == PCT_FS_IDLE |=> chan_a_match_flag)
    else $error("flag cleared without read");
  AST_NO_REQ: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ien_r[0] ##1 !ien_r[0] |-> !irq_request_pending)
    else $error("request while disabled");
  AST_LVL0: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    prio_r == 3'h0 |=> !irq_o)
    else $error("interrupt at level 0");
  AST_REQ_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req_set |=> irq_request_pending)
    else $error("request not raised");
  AST_IRQ_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_request_pending && prio_r != 3'h0 |=> irq_o)
    else $error("request not reaching interrupt output");
  AST_PIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chan_a_pin_oe_n_o)
    else $error("pin driven");

  COV_MATCH: cover property (@(posedge mclk_i) disable iff (!rst_n_i) match ##1 count_r == 16'h0000);
  COV_CLEAR: cover property (@(posedge mclk_i) disable iff (!rst_n_i) flag_clr);
  COV_IRQ: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule

/* verification/pct_top_tb_top.sv */
`timescale 1ns/10ps
`include "pct_cfg.svh"
module pct_top_tb_top;
  import pct_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pin_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, irq_o;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] irq_level;
  logic [31:0] rd;
  logic [1:0] rsp;
  int miscompares = 0;
  int check_count = 0;

  always #12.5 mclk_i = ~mclk_i;

  pct_top i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_a_pin_i(pin_in), .chan_a_pin_o(pin_o), .chan_a_pin_oe_n_o(pin_oe_n),
    .irq_level_o(irq_level), .irq_o(irq_o)
  );

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task hang;
    miscompares++;
    $display("[FAIL] %0t wait limit reached", $time);
    give_verdict();
  endtask

  // write one word, response code left in rsp
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40)
      hang();
  endtask

  // read one word into rd and rsp
  task rdw(input logic [7:0] a);
    int n;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40)
      hang();
  endtask

  task wait_irq(input logic e);
    int n;
    for (n = 0; n < 10; n++)
    begin
      @(posedge mclk_i);
      if (irq_o === e)
        break;
    end
    chk({31'h0, irq_o}, {31'h0, e}, "irq level output");
  endtask

  // run the counter until one match is seen in the status bit
  task run_match;
    int n;
    wr(`PCT_OFF_ISTAT, 32'h0000_0001);
    wr(`PCT_OFF_MODE, 32'h0000_0080);
    for (n = 0; n < 20; n++)
    begin
      rdw(`PCT_OFF_ISTAT);
      if (rd[0] === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    wr(`PCT_OFF_MODE, 32'h0000_0000);
  endtask

  task t_reset;
    logic [7:0] offs [6];
    logic [31:0] exps [6];
    int i;
    offs = '{`PCT_OFF_COUNT, `PCT_OFF_GRA, `PCT_OFF_GRB, `PCT_OFF_GRD, `PCT_OFF_STANDBY, `PCT_OFF_FLAGS};
    exps = '{32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h40, 32'h0};
    for (i = 0; i < 6; i++)
    begin
      rdw(offs[i]);
      chk(rd, exps[i], "reset value");
    end
    rdw(8'h40);
    chk(rd, 32'h0, "unmapped read data");
    chk({30'h0, rsp}, 32'h2, "unmapped read response");
    wr(8'h06, 32'h0000_0001);
    chk({30'h0, rsp}, 32'h2, "misaligned write");
    $display("test reset done");
  endtask

  task t_count;
    logic [31:0] c1;
    wr(`PCT_OFF_STANDBY, 32'h0000_0000);
    wr(`PCT_OFF_CTRL, 32'h0000_0025);
    wr(`PCT_OFF_MODE, 32'h0000_0080);
    rdw(`PCT_OFF_COUNT);
    chk(rd, 32'h0, "other source must not count");
    wr(`PCT_OFF_IOCTL, 32'h0000_0004);
    wr(`PCT_OFF_GRA, 32'h0000_0001);
    wr(`PCT_OFF_CTRL, 32'h0000_0026);
    rdw(`PCT_OFF_COUNT);
    chk({31'h0, rd > 32'h1}, 32'h1, "capture mode counts past A");
    rdw(`PCT_OFF_ISTAT);
    chk(rd, 32'h0, "capture mode gives no match");
    wr(`PCT_OFF_GRA, 32'h0000_FFFF);
    wr(`PCT_OFF_IOCTL, 32'h0000_0008);
    rdw(`PCT_OFF_COUNT);
    c1 = rd;
    rdw(`PCT_OFF_COUNT);
    chk({31'h0, rd > c1 && c1 != 0}, 32'h1, "counter advances");
    wr(`PCT_OFF_MODE, 32'h0000_0000);
    wr(`PCT_OFF_COUNT, 32'h0000_1234);
    rdw(`PCT_OFF_COUNT);
    chk(rd, 32'h1234, "stopped counter holds written value");
    rdw(`PCT_OFF_GRC);
    chk(rd, 32'hFFFF, "register C unchanged");
    wr(`PCT_OFF_IOCTL, 32'h0000_0000);
    $display("test count done");
  endtask

  task t_period;
    int i;
    wr(`PCT_OFF_COUNT, 32'h0000_0000);
    wr(`PCT_OFF_GRA, 32'h0000_0009);
    run_match();
    chk({31'h0, rd[0]}, 32'h1, "match seen");
    wr(`PCT_OFF_MODE, 32'h0000_0080);
    for (i = 0; i < 6; i++)
    begin
      rdw(`PCT_OFF_COUNT);
      chk({31'h0, rd <= 32'h9}, 32'h1, "count wraps at compare value");
    end
    wr(`PCT_OFF_MODE, 32'h0000_0000);
    chk({30'h0, pin_o, pin_oe_n}, 32'h1, "pin never driven");
    $display("test period done");
  endtask

  task t_flag;
    wr(`PCT_OFF_FLAGS, 32'h0000_0000);
    rdw(`PCT_OFF_FLAGS);
    chk({31'h0, rd[0]}, 32'h1, "clear without read ignored");
    wr(`PCT_OFF_FLAGS, 32'h0000_0000);
    wr(`PCT_OFF_FLAGS, 32'h0000_000F);
    rdw(`PCT_OFF_FLAGS);
    chk({31'h0, rd[0]}, 32'h0, "flag cleared");
    $display("test flag done");
  endtask

  task t_irq;
    wr(`PCT_OFF_ISTAT, 32'h0000_0001);
    wait_irq(1'b0);
    run_match();
    wr(`PCT_OFF_IRQCTL, 32'h0000_0001);
    wr(`PCT_OFF_IMASK, 32'h0000_0001);
    wait_irq(1'b1);
    wr(`PCT_OFF_ISTAT, 32'h0000_0001);
    wait_irq(1'b0);
    wr(`PCT_OFF_IMASK, 32'h0000_0000);
    rdw(`PCT_OFF_FLAGS);
    wr(`PCT_OFF_FLAGS, 32'h0000_0000);
    wr(`PCT_OFF_FLAGS, 32'h0000_000F);
    wait_irq(1'b0);
    wr(`PCT_OFF_IEN, 32'h0000_0001);
    run_match();
    wait_irq(1'b1);
    chk({29'h0, irq_level}, 32'h1, "level one");
    rdw(`PCT_OFF_FLAGS);
    wr(`PCT_OFF_FLAGS, 32'h0000_0000);
    wr(`PCT_OFF_FLAGS, 32'h0000_000F);
    rdw(`PCT_OFF_IRQCTL);
    chk(rd & 32'hF, 32'h9, "request held after flag clear");
    wr(`PCT_OFF_IRQCTL, 32'h0000_0001);
    wait_irq(1'b0);
    chk({29'h0, irq_level}, 32'h0, "no level when idle");
    run_match();
    wr(`PCT_OFF_IRQCTL, 32'h0000_0000);
    wait_irq(1'b0);
    wr(`PCT_OFF_IRQCTL, 32'h0000_0001);
    wait_irq(1'b1);
    $display("test irq done");
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_count();
    t_period();
    t_flag();
    t_irq();
    give_verdict();
  end
endmodule
